/* verilog/csp_defines.svh */
// Register indices, field positions, reset values and bus codes of the core status block
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// Register indices; byte address is four times the index
`define CSP_IDX_BANK 6'h04
`define CSP_IDX_TABLE_PTR_LOW 6'h07
`define CSP_IDX_TABLE_READ_HIGH_BYTE 6'h08
`define CSP_IDX_TABLE_PTR_HIGH 6'h09
`define CSP_IDX_FLAGS 6'h0A

// Flag positions inside the status byte
`define CSP_C_BIT 0
`define CSP_AC_BIT 1
`define CSP_Z_BIT 2
`define CSP_OV_BIT 3
`define CSP_PDF_BIT 4
`define CSP_TO_BIT 5
`define CSP_ARITH_MSB 3

// Reset values
`define CSP_FLAGS_RST 6'h00
`define CSP_BANK_RST 1'h0
`define CSP_BYTE_RST 8'h00

// Special registers below this address sit in every bank
`define CSP_SFR_TOP 8'h40

// Bus answers
`define CSP_RESP_OKAY 2'h0
`define CSP_RESP_DECERR 2'h3

`endif

/* verilog/csp_pkg.sv */
// Types shared by the core status block and its flag calculator
package csp_pkg;

	typedef enum logic [2:0] {
		CSP_OP_ADD = 3'b000,
		CSP_OP_ADC = 3'b001,
		CSP_OP_SUB = 3'b010,
		CSP_OP_SBC = 3'b011,
		CSP_OP_LOGIC = 3'b100,
		CSP_OP_RLC = 3'b101,
		CSP_OP_RRC = 3'b110
	} csp_alu_op_e;

	typedef enum logic [2:0] {
		CSP_PTR_NONE = 3'b000,
		CSP_PTR_INC_LOW = 3'b001,
		CSP_PTR_DEC_LOW = 3'b010,
		CSP_PTR_INC_HIGH = 3'b011,
		CSP_PTR_DEC_HIGH = 3'b100
	} csp_ptr_op_e;

	typedef enum logic [1:0] {
		CSP_DM_DIRECT = 2'b00,
		CSP_DM_IND_ONE = 2'b01,
		CSP_DM_IND_TWO = 2'b10
	} csp_dm_mode_e;

	typedef struct packed {
		logic valid;
		csp_alu_op_e op;
		logic [7:0] a;
		logic [7:0] b;
	} csp_alu_req_s;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} csp_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} csp_axi_rsp_s;

	typedef struct packed {
		logic bank_select_bit;
		logic [7:0] table_ptr_low;
		logic [7:0] table_ptr_high;
		logic [7:0] table_read_high_byte;
		logic [5:0] flags;
		logic tbl_busy;
		logic [7:0] tbl_low_byte;
		logic tbl_low_valid;
		logic [7:0] alu_result;
		logic alu_done;
		logic dm_bank;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		csp_axi_rsp_s rsp;
	} csp_state_s;

endpackage : csp_pkg

/* verilog/csp_flag_calc.sv */
// ALU flag calculator for add, subtract, logic and rotate-through-carry results
`timescale 1ns/10ps
module csp_flag_calc
	import csp_pkg::*;
(
	input wire csp_alu_op_e op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic [3:0] flags_new,
	output logic [3:0] upd_mask
);
	logic [7:0] bb;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] lo5;
	logic [7:0] lo8;

	always_comb begin
		// Subtract as a + ~b + 1 so carry out means no borrow
		bb = (op == CSP_OP_SUB || op == CSP_OP_SBC) ? ~b : b;
		unique case (op)
			CSP_OP_ADD: cin = 1'b0;
			CSP_OP_SUB: cin = 1'b1;
			default: cin = carry_in;
		endcase
		sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		lo5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		lo8 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
		result = sum9[7:0];
		flags_new = {lo8[7] ^ sum9[8], sum9[7:0] == 8'h00, lo5[4], sum9[8]};
		upd_mask = 4'hF;
		unique case (op)
			CSP_OP_LOGIC: begin
				result = a;
				flags_new = {1'b0, a == 8'h00, 2'b00};
				upd_mask = 4'h4;
			end
			CSP_OP_RLC: begin
				result = {a[6:0], carry_in};
				flags_new = {3'b000, a[7]};
				upd_mask = 4'h1;
			end
			CSP_OP_RRC: begin
				result = {carry_in, a[7:1]};
				flags_new = {3'b000, a[0]};
				upd_mask = 4'h1;
			end
			default: begin
			end
		endcase
	end
endmodule : csp_flag_calc

/* verilog/csp_core_status.sv */
// Core status flags, bank select and table pointer registers with an AXI4-Lite slave
//
// Function
// R01: Table pointers form the table read address
// R02: Table read loads high byte register
// R03: Bank register holds one bit, rest zero
// R04: Status writes touch only arithmetic flags
// R05: Carry from add, no-borrow, rotate
// R06: Half carry from low nibble
// R07: Zero flag tracks zero result
// R08: Overflow when msb carries differ
// R09: Power-down flag: halt sets, clear/power-up clears
// R10: Time-out flag: timeout sets, clear/halt/power-up clears
// R11: Flags never saved on calls or interrupts
// R12: Status eight bits, top two zero
// R13: Direct access hits bank zero only
// R14: Bank kept over watchdog reset in power-down
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`include "csp_defines.svh"
`timescale 1ns/10ps
module csp_core_status
	import csp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic rst_is_power_up,
	input wire logic rst_is_wdt_pd,
	input wire csp_axi_req_s axi_req,
	output csp_axi_rsp_s axi_rsp,
	input wire csp_alu_req_s alu_req,
	output logic [7:0] alu_result,
	output logic alu_done,
	input wire csp_ptr_op_e ptr_op,
	input wire logic tbl_rd_req,
	input wire logic pm_valid,
	input wire logic [15:0] pm_word,
	output logic [15:0] tbl_addr,
	output logic tbl_busy,
	output logic [7:0] tbl_low_byte,
	output logic tbl_low_valid,
	input wire logic halt_instr,
	input wire logic watchdog_clear_instr,
	input wire logic wdt_timeout,
	input wire logic dm_req,
	input wire csp_dm_mode_e dm_mode,
	input wire logic [7:0] dm_addr,
	output logic dm_bank,
	output logic [5:0] core_flags,
	output logic bank_select_bit
);
	csp_state_s s_reg;
	csp_state_s s_next;
	logic [7:0] calc_result;
	logic [3:0] calc_flags;
	logic [3:0] calc_mask;
	logic wr_fire;
	logic rd_fire;
	logic [5:0] rd_idx;

	csp_flag_calc u_flag_calc (
		.op(alu_req.op),
		.a(alu_req.a),
		.b(alu_req.b),
		.carry_in(s_reg.flags[`CSP_C_BIT]),
		.result(calc_result),
		.flags_new(calc_flags),
		.upd_mask(calc_mask)
	);

	function automatic logic reg_hit(input logic [5:0] idx);
		reg_hit = idx == `CSP_IDX_BANK || idx == `CSP_IDX_TABLE_PTR_LOW || idx == `CSP_IDX_TABLE_READ_HIGH_BYTE ||
			idx == `CSP_IDX_TABLE_PTR_HIGH || idx == `CSP_IDX_FLAGS;
	endfunction : reg_hit

	function automatic logic [31:0] read_word(input csp_state_s st, input logic [5:0] idx);
		read_word = 32'h0000_0000;
		// R03 upper bank bits read zero
		if (idx == `CSP_IDX_BANK) begin
			read_word = {31'h0000_0000, st.bank_select_bit};
		end
		if (idx == `CSP_IDX_TABLE_PTR_LOW) begin
			read_word = {24'h00_0000, st.table_ptr_low};
		end
		if (idx == `CSP_IDX_TABLE_READ_HIGH_BYTE) begin
			read_word = {24'h00_0000, st.table_read_high_byte};
		end
		if (idx == `CSP_IDX_TABLE_PTR_HIGH) begin
			read_word = {24'h00_0000, st.table_ptr_high};
		end
		// R12 top two status bits zero
		if (idx == `CSP_IDX_FLAGS) begin
			read_word = {26'h000_0000, st.flags};
		end
	endfunction : read_word

	assign rd_idx = axi_req.araddr[7:2];
	// Both halves of a write are held before it lands, so it lands in one cycle
	assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.rsp.bvalid;
	assign rd_fire = axi_req.arvalid && s_reg.rsp.arready;

	always_comb begin
		s_next = s_reg;
		s_next.tbl_low_valid = 1'b0;
		s_next.alu_done = 1'b0;

		// Write address and data channels, taken in either order
		if (axi_req.awvalid && s_reg.rsp.awready) begin
			s_next.aw_held = 1'b1;
			s_next.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_reg.rsp.wready) begin
			s_next.w_held = 1'b1;
			s_next.wdata = axi_req.wdata[7:0];
			s_next.wstrb0 = axi_req.wstrb[0];
		end
		if (s_reg.rsp.bvalid && axi_req.bready) begin
			s_next.rsp.bvalid = 1'b0;
		end
		if (wr_fire) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.rsp.bvalid = 1'b1;
			s_next.rsp.bresp = reg_hit(s_reg.awaddr[7:2]) ? `CSP_RESP_OKAY : `CSP_RESP_DECERR;
			// Only byte lane 0 carries register data
			if (s_reg.wstrb0) begin
				// R03 only the low bank bit is stored
				if (s_reg.awaddr[7:2] == `CSP_IDX_BANK) begin
					s_next.bank_select_bit = s_reg.wdata[0];
				end
				if (s_reg.awaddr[7:2] == `CSP_IDX_TABLE_PTR_LOW) begin
					s_next.table_ptr_low = s_reg.wdata;
				end
				if (s_reg.awaddr[7:2] == `CSP_IDX_TABLE_PTR_HIGH) begin
					s_next.table_ptr_high = s_reg.wdata;
				end
				// R04 time-out and power-down bits ignore writes
				if (s_reg.awaddr[7:2] == `CSP_IDX_FLAGS) begin
					s_next.flags[`CSP_ARITH_MSB:0] = s_reg.wdata[`CSP_ARITH_MSB:0];
				end
			end
		end

		// Read channel answers the cycle after the address is taken
		if (s_reg.rsp.rvalid && axi_req.rready) begin
			s_next.rsp.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_next.rsp.rvalid = 1'b1;
			s_next.rsp.rdata = read_word(s_reg, rd_idx);
			s_next.rsp.rresp = reg_hit(rd_idx) ? `CSP_RESP_OKAY : `CSP_RESP_DECERR;
		end

		// R01 pointer steps from the datapath win over a bus write in the same cycle
		unique case (ptr_op)
			CSP_PTR_INC_LOW: s_next.table_ptr_low = s_reg.table_ptr_low + 8'h01;
			CSP_PTR_DEC_LOW: s_next.table_ptr_low = s_reg.table_ptr_low - 8'h01;
			CSP_PTR_INC_HIGH: s_next.table_ptr_high = s_reg.table_ptr_high + 8'h01;
			CSP_PTR_DEC_HIGH: s_next.table_ptr_high = s_reg.table_ptr_high - 8'h01;
			default: begin
			end
		endcase

		// R01 table read starts with the current pointer pair as address
		if (tbl_rd_req && !s_reg.tbl_busy) begin
			s_next.tbl_busy = 1'b1;
		end
		// R02 high byte kept here, low byte handed back to the datapath
		if (s_reg.tbl_busy && pm_valid) begin
			s_next.tbl_busy = 1'b0;
			s_next.table_read_high_byte = pm_word[15:8];
			s_next.tbl_low_byte = pm_word[7:0];
			s_next.tbl_low_valid = 1'b1;
		end

		// R05 R06 R07 R08 ALU result wins over a same-cycle status write
		if (alu_req.valid) begin
			s_next.alu_result = calc_result;
			s_next.alu_done = 1'b1;
			for (int i = 0; i <= `CSP_ARITH_MSB; i++) begin
				if (calc_mask[i]) begin
					s_next.flags[i] = calc_flags[i];
				end
			end
		end

		// R09 halt sets, watchdog clear clears
		if (halt_instr) begin
			s_next.flags[`CSP_PDF_BIT] = 1'b1;
		end else if (watchdog_clear_instr) begin
			s_next.flags[`CSP_PDF_BIT] = 1'b0;
		end
		// R10 a timeout in the clearing cycle is not lost
		if (wdt_timeout) begin
			s_next.flags[`CSP_TO_BIT] = 1'b1;
		end else if (watchdog_clear_instr || halt_instr) begin
			s_next.flags[`CSP_TO_BIT] = 1'b0;
		end

		// R13 direct and first-pointer accesses and special registers use bank zero
		if (dm_req) begin
			s_next.dm_bank = (dm_mode == CSP_DM_IND_TWO && dm_addr >= `CSP_SFR_TOP) ?
				s_reg.bank_select_bit : 1'b0;
		end

		// R11 flags live only here; calls and interrupts never copy them out
		s_next.rsp.awready = !s_next.aw_held && !s_next.rsp.bvalid;
		s_next.rsp.wready = !s_next.w_held && !s_next.rsp.bvalid;
		s_next.rsp.arready = !s_next.rsp.rvalid;

		if (!rst_n) begin
			s_next.table_ptr_low = `CSP_BYTE_RST;
			s_next.table_ptr_high = `CSP_BYTE_RST;
			s_next.table_read_high_byte = `CSP_BYTE_RST;
			s_next.tbl_busy = 1'b0;
			s_next.tbl_low_byte = `CSP_BYTE_RST;
			s_next.tbl_low_valid = 1'b0;
			s_next.alu_result = `CSP_BYTE_RST;
			s_next.alu_done = 1'b0;
			s_next.dm_bank = `CSP_BANK_RST;
			s_next.aw_held = 1'b0;
			s_next.awaddr = `CSP_BYTE_RST;
			s_next.w_held = 1'b0;
			s_next.wdata = `CSP_BYTE_RST;
			s_next.wstrb0 = 1'b0;
			s_next.rsp = '0;
			// R12 arithmetic flags have no documented reset; zero keeps them defined
			s_next.flags[`CSP_ARITH_MSB:0] = 4'(`CSP_FLAGS_RST);
			// R09 R10 R12 power-up clears the system flags, other resets leave them
			if (rst_is_power_up) begin
				s_next.flags = `CSP_FLAGS_RST;
			end
			// R14 a watchdog reset while powered down leaves the bank alone
			if (!rst_is_wdt_pd) begin
				s_next.bank_select_bit = `CSP_BANK_RST;
			end
		end
	end

	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	assign axi_rsp = s_reg.rsp;
	assign alu_result = s_reg.alu_result;
	assign alu_done = s_reg.alu_done;
	assign tbl_addr = {s_reg.table_ptr_high, s_reg.table_ptr_low};
	assign tbl_busy = s_reg.tbl_busy;
	assign tbl_low_byte = s_reg.tbl_low_byte;
	assign tbl_low_valid = s_reg.tbl_low_valid;
	assign dm_bank = s_reg.dm_bank;
	assign core_flags = s_reg.flags;
	assign bank_select_bit = s_reg.bank_select_bit;

	// Checks
	table_high_load_a: assert property ( // R02
		@(posedge mclk) disable iff (!rst_n)
		tbl_busy && pm_valid |=> tbl_low_valid && s_reg.table_read_high_byte == $past(pm_word[15:8]))
		else $error("table read high byte not loaded");

	status_write_ro_a: assert property ( // R04
		@(posedge mclk) disable iff (!rst_n)
		wr_fire && s_reg.awaddr[7:2] == `CSP_IDX_FLAGS && !halt_instr && !watchdog_clear_instr && !wdt_timeout
		|=> $stable(core_flags[5:4]))
		else $error("status write changed system flags");

	carry_on_add_a: assert property ( // R05
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_ADD
		|=> core_flags[`CSP_C_BIT] == $past(({1'b0, alu_req.a} + {1'b0, alu_req.b}) > 9'h0FF))
		else $error("carry flag wrong after add");

	half_carry_add_a: assert property ( // R06
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_ADD
		|=> core_flags[`CSP_AC_BIT] == $past(({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}) > 5'h0F))
		else $error("half carry flag wrong after add");

	zero_on_logic_a: assert property ( // R07
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_LOGIC |=> core_flags[`CSP_Z_BIT] == ($past(alu_req.a) == 8'h00))
		else $error("zero flag disagrees with result");

	overflow_sign_a: assert property ( // R08
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_ADD && alu_req.a[7] == alu_req.b[7]
		|=> core_flags[`CSP_OV_BIT] == (alu_result[7] != $past(alu_req.a[7])))
		else $error("overflow flag wrong after add");

	pdf_on_halt_a: assert property ( // R09
		@(posedge mclk) disable iff (!rst_n)
		(halt_instr |=> core_flags[`CSP_PDF_BIT]) and
		(watchdog_clear_instr && !halt_instr |=> !core_flags[`CSP_PDF_BIT]))
		else $error("power-down flag wrong");

	timeout_flag_a: assert property ( // R10
		@(posedge mclk) disable iff (!rst_n)
		(wdt_timeout |=> core_flags[`CSP_TO_BIT]) and
		(!wdt_timeout && (halt_instr || watchdog_clear_instr) |=> !core_flags[`CSP_TO_BIT]))
		else $error("time-out flag wrong");

	direct_bank_zero_a: assert property ( // R13
		@(posedge mclk) disable iff (!rst_n)
		dm_req && dm_mode != CSP_DM_IND_TWO |=> !dm_bank)
		else $error("direct access left bank zero");

	indirect_bank_a: assert property ( // R13
		@(posedge mclk) disable iff (!rst_n)
		dm_req && dm_mode == CSP_DM_IND_TWO && dm_addr >= `CSP_SFR_TOP
		|=> dm_bank == $past(bank_select_bit))
		else $error("second pointer ignored bank select");

	carry_on_sub_a: assert property ( // R05
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_SUB
		|=> core_flags[`CSP_C_BIT] == $past(alu_req.a >= alu_req.b))
		else $error("carry flag wrong after subtract");

	rotate_carry_a: assert property ( // R05
		@(posedge mclk) disable iff (!rst_n)
		(alu_req.valid && alu_req.op == CSP_OP_RLC |=> core_flags[`CSP_C_BIT] == $past(alu_req.a[7])) and
		(alu_req.valid && alu_req.op == CSP_OP_RRC |=> core_flags[`CSP_C_BIT] == $past(alu_req.a[0])))
		else $error("carry flag wrong after rotate");

	half_carry_sub_a: assert property ( // R06
		@(posedge mclk) disable iff (!rst_n)
		alu_req.valid && alu_req.op == CSP_OP_SUB
		|=> core_flags[`CSP_AC_BIT] == $past(alu_req.a[3:0] >= alu_req.b[3:0]))
		else $error("half carry flag wrong after subtract");

	bank_read_zero_a: assert property ( // R03
		@(posedge mclk) disable iff (!rst_n)
		rd_fire && rd_idx == `CSP_IDX_BANK
		|=> axi_rsp.rdata[31:1] == 31'h0000_0000 && axi_rsp.rdata[0] == $past(bank_select_bit))
		else $error("bank register read wrong");

	status_top_zero_a: assert property ( // R12
		@(posedge mclk) disable iff (!rst_n)
		rd_fire && rd_idx == `CSP_IDX_FLAGS |=> axi_rsp.rdata[7:6] == 2'b00)
		else $error("status top bits not zero");

	pointer_step_a: assert property ( // R01
		@(posedge mclk) disable iff (!rst_n)
		(ptr_op == CSP_PTR_INC_LOW |=> tbl_addr[7:0] == $past(tbl_addr[7:0]) + 8'h01) and
		(ptr_op == CSP_PTR_DEC_HIGH |=> tbl_addr[15:8] == $past(tbl_addr[15:8]) - 8'h01))
		else $error("table pointer step wrong");

	// No disable here: these watch the reset itself
	bank_reset_a: assert property ( // R14
		@(posedge mclk)
		(!rst_n && !rst_is_wdt_pd |=> !bank_select_bit) and
		(!rst_n && rst_is_wdt_pd |=> $stable(bank_select_bit)))
		else $error("bank select reset wrong");

	power_up_clear_a: assert property ( // R10
		@(posedge mclk)
		!rst_n && rst_is_power_up |=> core_flags[5:4] == 2'b00)
		else $error("power-up left system flags set");

endmodule : csp_core_status

/* test/csp_pm_model.sv */
// Program memory model answering table reads from the pointer address
`timescale 1ns/10ps
module csp_pm_model
	import csp_pkg::*;
(
	input wire logic mclk,
	input wire logic tbl_busy,
	input wire logic [15:0] tbl_addr,
	input wire logic [1:0] stall,
	output logic pm_valid,
	output logic [15:0] pm_word
);
	logic [1:0] cnt_reg = 2'h0;
	initial begin
		pm_valid = 1'b0;
		pm_word = 16'h0000;
	end
	// Word toggles when idle so a stale value is never mistaken for data
	always @(posedge mclk) begin
		pm_word <= ~pm_word;
		pm_valid <= 1'b0;
		cnt_reg <= 2'h0;
		if (tbl_busy && !pm_valid) begin
			cnt_reg <= cnt_reg + 2'h1;
			if (cnt_reg == stall) begin
				pm_valid <= 1'b1;
				pm_word <= {tbl_addr[7:0], tbl_addr[15:8]} ^ 16'ha5c3;
			end
		end
	end
endmodule : csp_pm_model

/* test/csp_core_status_tb.sv */
// Self-checking bench of the core status block
`timescale 1ns/10ps
module csp_core_status_tb
	import csp_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, rst_is_power_up = 1'b1, rst_is_wdt_pd = 1'b0;
	csp_axi_req_s ax = '0;
	csp_axi_rsp_s rs;
	csp_alu_req_s alu = '0;
	csp_ptr_op_e ptr_op = CSP_PTR_NONE;
	logic tbl_rd_req = 1'b0, pm_valid, tbl_busy, tbl_low_valid, alu_done, dm_bank, bank_select_bit;
	logic halt_instr = 1'b0, watchdog_clear_instr = 1'b0, wdt_timeout = 1'b0, dm_req = 1'b0;
	csp_dm_mode_e dm_mode = CSP_DM_DIRECT;
	logic [7:0] dm_addr = 8'h00, alu_result, tbl_low_byte, x, y;
	logic [15:0] pm_word, tbl_addr, pw;
	logic [5:0] core_flags;
	logic [1:0] stall = 2'h0, es = 2'h0, r;
	logic [3:0] ef = 4'h0;
	logic [31:0] d;
	logic [11:0] e;
	logic [2:0] o;
	logic [4:0] st [8] = '{5'h11, 5'h07, 5'h11, 5'h08, 5'h06, 5'h08, 5'h19, 5'h0e};
	logic [10:0] dmt [4] = '{11'h0a0, 11'h4a1, 11'h420, 11'h2a0};
	int seed = 32'h0000_3865, num_errors = 0, tests_run = 0, n;
	always #2.5 mclk = ~mclk;
	csp_core_status dut_u (.mclk(mclk), .rst_n(rst_n), .rst_is_power_up(rst_is_power_up),
		.rst_is_wdt_pd(rst_is_wdt_pd), .axi_req(ax), .axi_rsp(rs), .alu_req(alu), .alu_result(alu_result),
		.alu_done(alu_done), .ptr_op(ptr_op), .tbl_rd_req(tbl_rd_req), .pm_valid(pm_valid), .pm_word(pm_word),
		.tbl_addr(tbl_addr), .tbl_busy(tbl_busy), .tbl_low_byte(tbl_low_byte), .tbl_low_valid(tbl_low_valid),
		.halt_instr(halt_instr), .watchdog_clear_instr(watchdog_clear_instr), .wdt_timeout(wdt_timeout),
		.dm_req(dm_req), .dm_mode(dm_mode), .dm_addr(dm_addr), .dm_bank(dm_bank), .core_flags(core_flags),
		.bank_select_bit(bank_select_bit));
	csp_pm_model pm_u (.mclk(mclk), .tbl_busy(tbl_busy), .tbl_addr(tbl_addr), .stall(stall),
		.pm_valid(pm_valid), .pm_word(pm_word));
	function automatic logic [15:0] pm_of(input logic [15:0] ad);
		return {ad[7:0], ad[15:8]} ^ 16'ha5c3;
	endfunction : pm_of
	// Result and {ovf, zero, half, carry}; subtract adds the inverse with no-borrow as carry in
	function automatic logic [11:0] alu_exp(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic [3:0] f);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] l, bb, q;
		logic ci;
		logic [3:0] m;
		bb = op[1] ? ~b : b;
		ci = op[0] ? f[0] : op[1];
		s = a + bb + ci;
		h = a[3:0] + bb[3:0] + ci;
		l = a[6:0] + bb[6:0] + ci;
		q = s[7:0];
		m = {l[7] ^ s[8], q == 8'h00, h[4], s[8]};
		if (op == 3'h4) begin
			q = a;
			m = {f[3], a == 8'h00, f[1:0]};
		end
		if (op == 3'h5) begin
			q = {a[6:0], f[0]};
			m = {f[3:1], a[7]};
		end
		if (op == 3'h6) begin
			q = {f[0], a[7:1]};
			m = {f[3:1], a[0]};
		end
		return {q, m};
	endfunction : alu_exp
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] resp);
		ax.awvalid <= 1'b1;
		ax.awaddr <= ad;
		ax.wvalid <= 1'b1;
		ax.wdata <= wd;
		ax.wstrb <= 4'hf;
		ax.bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (rs.awready) ax.awvalid <= 1'b0;
			if (rs.wready) ax.wvalid <= 1'b0;
		end while (rs.bvalid !== 1'b1);
		resp = rs.bresp;
	endtask : axw
	task automatic axr(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] resp);
		ax.arvalid <= 1'b1;
		ax.araddr <= ad;
		ax.rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (rs.arready) ax.arvalid <= 1'b0;
		end while (rs.rvalid !== 1'b1);
		rd = rs.rdata;
		resp = rs.rresp;
	endtask : axr
	task automatic sys(input logic [2:0] hct);
		{halt_instr, watchdog_clear_instr, wdt_timeout} <= hct;
		tick(1);
		{halt_instr, watchdog_clear_instr, wdt_timeout} <= 3'h0;
		tick(1);
	endtask : sys
	task automatic rst(input logic pu, input logic wp);
		rst_n <= 1'b0;
		rst_is_power_up <= pu;
		rst_is_wdt_pd <= wp;
		tick(2);
		rst_n <= 1'b1;
		tick(2);
	endtask : rst
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
	initial begin
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		axr(8'h28, d, r); chk(d, 32'h0000_0000);
		axw(8'h10, 32'h0000_00ff, r); axr(8'h10, d, r); chk(d, 32'h0000_0001);
		axr(8'hfc, d, r); chk(r, 2'h3);
		axw(8'hfc, 32'h0000_00ff, r); chk(r, 2'h3);
		axw(8'h28, 32'h0000_00ff, r); ef = 4'hf; axr(8'h28, d, r); chk(d, 32'h0000_000f);
		for (int i = 0; i < 40; i++) begin
			o = (i == 0) ? 3'h0 : 3'($unsigned($random(seed)) % 7);
			x = (i == 0) ? 8'h7f : 8'($random(seed));
			y = (i == 0) ? 8'h01 : 8'($random(seed));
			alu.valid <= 1'b1; alu.op <= csp_alu_op_e'(o); alu.a <= x; alu.b <= y;
			tick(1);
			alu.valid <= 1'b0;
			tick(1);
			e = alu_exp(o, x, y, ef);
			ef = e[3:0];
			chk(alu_done, 1'b1); chk(alu_result, e[11:4]);
			chk(core_flags, {es, ef});
		end
		for (int i = 0; i < 8; i++) begin
			sys(st[i][4:2]); es = st[i][1:0];
			chk(core_flags[5:4], es);
			if (i == 4) begin
				axw(8'h28, 32'h0000_0030, r); ef = 4'h0; tick(1); chk(core_flags, {es, ef});
			end
		end
		axw(8'h1c, 32'h0000_0034, r); axw(8'h24, 32'h0000_0012, r);
		ptr_op <= CSP_PTR_INC_LOW; tick(1); ptr_op <= CSP_PTR_DEC_HIGH; tick(1); ptr_op <= CSP_PTR_NONE; tick(2);
		chk(tbl_addr, 16'h1135);
		for (int k = 0; k < 2; k++) begin
			stall <= 2'(k * 3); tbl_rd_req <= 1'b1; tick(1); tbl_rd_req <= 1'b0;
			n = 0;
			while (tbl_low_valid !== 1'b1 && n < 20) begin
				tick(1); n++;
			end
			pw = pm_of(tbl_addr);
			chk(tbl_low_byte, pw[7:0]); tick(1);
			axw(8'h20, 32'h0000_0000, r); axr(8'h20, d, r); chk(d, pw[15:8]);
			ptr_op <= CSP_PTR_DEC_LOW; tick(1); ptr_op <= CSP_PTR_INC_HIGH; tick(1); ptr_op <= CSP_PTR_NONE; tick(2);
		end
		chk(tbl_addr, 16'h1333);
		for (int i = 0; i < 4; i++) begin
			dm_req <= 1'b1; dm_mode <= csp_dm_mode_e'(dmt[i][10:9]); dm_addr <= dmt[i][8:1];
			tick(1); dm_req <= 1'b0; tick(1);
			chk(dm_bank, dmt[i][0]);
		end
		sys(3'h4);
		rst(1'b0, 1'b1); chk(bank_select_bit, 1'b1); chk(core_flags, 6'h10);
		rst(1'b1, 1'b0); chk(bank_select_bit, 1'b0); chk(core_flags, 6'h00);
		report_and_stop();
	end
endmodule : csp_core_status_tb
